// ===== verilog/ogd_top.sv
// output gating, divider sync, power-down and serial select
`timescale 1ns/1ns
`include "ogd_consts.svh"
// What this block does
// - global disable pin high turns every output off
// - per-output disable bit turns that output off
// - lock loss keeps outputs running unless its disable option is set
// - reference loss disables all outputs unless the keep option is set
// - a disabled output parks at a selectable low or high level
// - sync mode switches an output only at a period boundary
// - without sync mode, power-down or free-run a disable takes effect at once
// - power-up, reset pin and reset bit put dividers in a common state
// - divider sync bit realigns dividers without resetting anything else
// - power-down keeps configuration, stops clocks, serial port stays alive
// - power-down entry happens on full-period boundaries; exit does only in sync mode or while the loop is free-running
// - after power-down each loop is free-running until it locks
// - default configuration loads from the store before operation
// - store takes two programming passes; only the newest is used
// - serial select pin chooses the two-wire or four-wire port
// - three-wire bit picks one shared data line or separate lines
// - single-ended drivers toggle both pins unless one-pin mode is set
// - complement pin in phase by default; polarity bits invert pins
module ogd_top
   import ogd_pkg::*;
#(
   parameter int NO = `OGD_NUM_OUT,
   parameter int NL = `OGD_NUM_LOOP,
   parameter int DIV_W = `OGD_DIV_W,
   parameter int LOAD_CYC = `OGD_LOAD_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_global_output_disable_pin,
   input wire logic i_power_down_pin_n,
   input wire logic i_device_reset_pin_n,
   input wire logic i_i2c_sel_pin,
   input wire logic i_reset_bit,
   input wire logic i_div_sync_bit,
   input wire logic [NL-1:0] i_loss_of_lock,
   input wire logic i_reference_loss_alarm,
   input wire logic [NO*$clog2(NL)-1:0] i_out_loop_sel,
   input wire logic [NO*DIV_W-1:0] i_half,
   input wire logic i_cfg_wr,
   input wire logic [NO*`OGD_F_W+`OGD_G_W-1:0] i_cfg_wdata,
   output logic [NO*`OGD_F_W+`OGD_G_W-1:0] o_cfg_rdata,
   input wire logic i_prog_stb,
   output logic [1:0] o_otp_passes,
   output logic o_prog_refused,
   output logic o_cfg_loaded,
   input wire logic i_spi_dout,
   input wire logic i_spi_dout_en,
   input wire logic i_sdi_pin,
   input wire logic i_sdio_pin,
   output logic o_spi_din,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   output logic o_sdio,
   output logic o_sdio_oe_n,
   output logic o_i2c_mode,
   output logic [NO-1:0] o_clock_out_true,
   output logic [NO-1:0] o_clock_out_comp,
   output logic [NO-1:0] o_out_active,
   output logic [NO-1:0] o_out_enable,
   output logic [NL-1:0] o_loop_freerun,
   output logic o_low_power,
   output logic o_div_rst
);
   localparam int CFG_W = NO * `OGD_F_W + `OGD_G_W;
   localparam int SEL_W = $clog2(NL);
   localparam int PIN_OE = 0;
   localparam int PIN_PDN = 1;
   localparam int PIN_RST = 2;
   localparam int PIN_I2C = 3;
   localparam logic [CFG_W-1:0] FACTORY = {`OGD_GLB_RST, {NO{`OGD_OUT_RST}}};

   typedef struct packed {
      logic [3:0] p1;
      logic [3:0] p2;
      logic [1:0] d1;
      logic [1:0] d2;
      logic [CFG_W-1:0] cfg;
      logic [NO-1:0] en;
      logic [NL-1:0] fr;
      logic dr;
      logic sdo;
      logic sdo_oen;
      logic sdio;
      logic sdio_oen;
      logic din;
   } ogd_top_t;
   ogd_top_t s_q, s_d;

   logic [CFG_W-1:0] otp_cfg;
   logic load_done;
   logic loaded;
   logic pd;
   logic ref_off;
   logic three;
   logic spi_on;
   logic [NO-1:0] force_sync;

   function automatic logic fld(input logic [CFG_W-1:0] c, input int o, input int f);
      fld = c[o * `OGD_F_W + f];
   endfunction

   function automatic logic glb(input logic [CFG_W-1:0] c, input int f);
      glb = c[NO * `OGD_F_W + f];
   endfunction

   function automatic logic lol_of(input logic [NO*SEL_W-1:0] sel,
                                   input logic [NL-1:0] loss_of_lock, input int o);
      lol_of = loss_of_lock[sel[o*SEL_W +: SEL_W]];
   endfunction

   ogd_cfg_store #(
      .CFG_W(CFG_W),
      .DEFAULT_IMG(FACTORY),
      .LOAD_CYC(LOAD_CYC)
   ) u_store (
      .i_clk(i_clk),
      .i_reset_n(i_reset_n),
      // reset pin and reset bit reload just like power-up
      .i_reload(i_reset_bit || !s_q.p2[PIN_RST]),
      .i_prog_stb(i_prog_stb),
      .i_prog_img(s_q.cfg),
      .o_cfg(otp_cfg),
      .o_load_done(load_done),
      .o_loaded(loaded),
      .o_passes(o_otp_passes),
      .o_prog_refused(o_prog_refused)
   );

   always_comb begin
      s_d = s_q;
      s_d.p1 = {i_i2c_sel_pin, i_device_reset_pin_n, i_power_down_pin_n,
                i_global_output_disable_pin};
      s_d.p2 = s_q.p1;
      s_d.d1 = {i_sdi_pin, i_sdio_pin};
      s_d.d2 = s_q.d1;
      pd = !s_q.p2[PIN_PDN];
      // config survives power-down; only a load or a write replaces it
      if (load_done) s_d.cfg = otp_cfg;
      else if (i_cfg_wr) s_d.cfg = i_cfg_wdata;
      s_d.dr = !s_q.p2[PIN_RST] || i_reset_bit || !loaded;
      if (i_div_sync_bit) s_d.dr = 1'b1;
      ref_off = i_reference_loss_alarm && !glb(s_q.cfg, `OGD_G_REF_KEEP);
      for (int i = 0; i < NO; i++) begin
         s_d.en[i] = !s_q.p2[PIN_OE]
                     && !fld(s_q.cfg, i, `OGD_F_DIS)
                     && !(fld(s_q.cfg, i, `OGD_F_LOL_DIS)
                          && lol_of(i_out_loop_sel, i_loss_of_lock, i))
                     && !ref_off && !pd && loaded && !s_q.dr;
      end
      for (int l = 0; l < NL; l++) begin
         if (pd) s_d.fr[l] = 1'b1;
         else if (!i_loss_of_lock[l]) s_d.fr[l] = 1'b0;
      end
      three = glb(s_q.cfg, `OGD_G_3WIRE);
      spi_on = !s_q.p2[PIN_I2C];
      // three-wire shares one line, so only one driver may ever turn on
      s_d.din = three ? s_q.d2[0] : s_q.d2[1];
      s_d.sdio_oen = !(spi_on && three && i_spi_dout_en);
      s_d.sdo_oen = !(spi_on && !three && i_spi_dout_en);
      s_d.sdo = i_spi_dout;
      s_d.sdio = i_spi_dout;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) s_q <= '{p1: `OGD_PIN_RST, p2: `OGD_PIN_RST, d1: 2'h0, d2: 2'h0,
                               cfg: '0, en: '0, fr: '1, dr: 1'b1, sdo: 1'b0,
                               sdo_oen: 1'b1, sdio: 1'b0, sdio_oen: 1'b1, din: 1'b0};
      else s_q <= s_d;
   end

   // power-down and free-run force boundary switching so no runt escapes
   always_comb begin
      for (int i = 0; i < NO; i++) begin
         force_sync[i] = pd || s_q.fr[i_out_loop_sel[i*SEL_W +: SEL_W]];
      end
   end

   genvar g;
   generate
      for (g = 0; g < NO; g++) begin : g_out
         ogd_out_drv #(
            .DIV_W(DIV_W)
         ) u_drv (
            .i_clk(i_clk),
            .i_reset_n(i_reset_n),
            .i_div_rst(s_q.dr),
            .i_half(i_half[g*DIV_W +: DIV_W]),
            .i_en(s_q.en[g]),
            .i_sync_en(fld(s_q.cfg, g, `OGD_F_SYNC)),
            .i_force_sync(force_sync[g]),
            .i_idle_hi(fld(s_q.cfg, g, `OGD_F_IDLE_HI)),
            .i_single(fld(s_q.cfg, g, `OGD_F_SINGLE)),
            .i_inv_t(fld(s_q.cfg, g, `OGD_F_INV_T)),
            .i_inv_c(fld(s_q.cfg, g, `OGD_F_INV_C)),
            .o_true(o_clock_out_true[g]),
            .o_comp(o_clock_out_comp[g]),
            .o_active(o_out_active[g])
         );
      end
   endgenerate

   assign o_cfg_rdata = s_q.cfg;
   assign o_cfg_loaded = loaded;
   assign o_out_enable = s_q.en;
   assign o_loop_freerun = s_q.fr;
   assign o_low_power = !s_q.p2[PIN_PDN];
   assign o_div_rst = s_q.dr;
   assign o_i2c_mode = s_q.p2[PIN_I2C];
   assign o_spi_din = s_q.din;
   assign o_sdo = s_q.sdo;
   assign o_sdo_oe_n = s_q.sdo_oen;
   assign o_sdio = s_q.sdio;
   assign o_sdio_oe_n = s_q.sdio_oen;

   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_reset_n);

   property p_oe_off;
      s_q.p2[PIN_OE] |=> (o_out_enable == '0);
   endproperty
   a_oe_off: assert property (p_oe_off) else $error("enable under pin disable");

   property p_own_dis;
      fld(s_q.cfg, 0, `OGD_F_DIS) |=> !o_out_enable[0];
   endproperty
   a_own_dis: assert property (p_own_dis) else $error("own disable ignored");

   property p_lol_dis;
      (fld(s_q.cfg, 0, `OGD_F_LOL_DIS) && lol_of(i_out_loop_sel, i_loss_of_lock, 0))
         |=> !o_out_enable[0];
   endproperty
   a_lol_dis: assert property (p_lol_dis) else $error("lock-loss disable ignored");

   property p_ref_off;
      (i_reference_loss_alarm && !glb(s_q.cfg, `OGD_G_REF_KEEP)) |=> (o_out_enable == '0);
   endproperty
   a_ref_off: assert property (p_ref_off) else $error("reference loss ignored");

   property p_all_on;
      (!s_q.p2[PIN_OE] && !fld(s_q.cfg, 0, `OGD_F_DIS) && !fld(s_q.cfg, 0, `OGD_F_LOL_DIS)
       && !i_reference_loss_alarm && s_q.p2[PIN_PDN] && loaded && !s_q.dr)
         |=> o_out_enable[0];
   endproperty
   a_all_on: assert property (p_all_on) else $error("enable missing");

   sequence s_pd_low;
      !s_q.p2[PIN_PDN];
   endsequence
   property p_pd;
      s_pd_low |=> (o_out_enable == '0) ##0 s_q.p2[PIN_PDN] || o_low_power;
   endproperty
   a_pd: assert property (p_pd) else $error("clocks during power-down");

   property p_wake;
      ($rose(s_q.p2[PIN_PDN]) && i_loss_of_lock[0]) |-> o_loop_freerun[0] ##1 o_loop_freerun[0];
   endproperty
   a_wake: assert property (p_wake) else $error("no free-run after wake");

   property p_sync;
      i_div_sync_bit |=> (o_div_rst && $stable(o_cfg_rdata));
   endproperty
   a_sync: assert property (p_sync) else $error("sync did not realign");

   sequence s_rst_pin;
      !i_device_reset_pin_n ##3 1;
   endsequence
   property p_rst_pin;
      s_rst_pin |-> o_div_rst;
   endproperty
   a_rst_pin: assert property (p_rst_pin) else $error("reset pin missed");

   property p_i2c;
      $past(i_reset_n, 2) |-> (o_i2c_mode == $past(i_i2c_sel_pin, 2));
   endproperty
   a_i2c: assert property (p_i2c) else $error("port select wrong");

   property p_3w;
      (glb(s_q.cfg, `OGD_G_3WIRE) && !o_i2c_mode && i_spi_dout_en) |=> (!o_sdio_oe_n && o_sdo_oe_n);
   endproperty
   a_3w: assert property (p_3w) else $error("three-wire line not driven");

   property p_4w;
      (!glb(s_q.cfg, `OGD_G_3WIRE) && !o_i2c_mode && i_spi_dout_en) |=> (!o_sdo_oe_n && o_sdio_oe_n);
   endproperty
   a_4w: assert property (p_4w) else $error("four-wire line not driven");

   // both pins driven at once would fight on a shared line
   property p_one_drv;
      (o_sdo_oe_n || o_sdio_oe_n);
   endproperty
   a_one_drv: assert property (p_one_drv) else $error("both data lines driven");

   property p_din_sel;
      glb(s_q.cfg, `OGD_G_3WIRE) |=> (o_spi_din == $past(s_q.d2[0]));
   endproperty
   a_din_sel: assert property (p_din_sel) else $error("wrong data-in line");

   property p_i2c_quiet;
      (o_i2c_mode && $past(o_i2c_mode)) |-> (o_sdo_oe_n && o_sdio_oe_n);
   endproperty
   a_i2c_quiet: assert property (p_i2c_quiet) else $error("spi driver on in i2c mode");

   property p_single;
      fld(s_q.cfg, 0, `OGD_F_SINGLE)
         |=> (o_clock_out_comp[0] == $past(fld(s_q.cfg, 0, `OGD_F_IDLE_HI)));
   endproperty
   a_single: assert property (p_single) else $error("complement not parked");

   property p_in_phase;
      (!fld(s_q.cfg, 0, `OGD_F_INV_T) && !fld(s_q.cfg, 0, `OGD_F_INV_C)
       && !fld(s_q.cfg, 0, `OGD_F_SINGLE)) |=> (o_clock_out_true[0] == o_clock_out_comp[0]);
   endproperty
   a_in_phase: assert property (p_in_phase) else $error("pins out of phase");

   property p_load_dr;
      !o_cfg_loaded |=> o_div_rst;
   endproperty
   a_load_dr: assert property (p_load_dr) else $error("dividers free before load");

   property p_fr_clear;
      (!o_low_power && !i_loss_of_lock[0]) |=> !o_loop_freerun[0];
   endproperty
   a_fr_clear: assert property (p_fr_clear) else $error("free-run after lock");

   property p_pd_keep;
      (o_low_power && !i_cfg_wr && !load_done) |=> $stable(o_cfg_rdata);
   endproperty
   a_pd_keep: assert property (p_pd_keep) else $error("config lost in power-down");
endmodule

// ===== pkg/ogd_consts.svh
// constants for output gating and divider sync
`ifndef OGD_CONSTS_SVH
`define OGD_CONSTS_SVH
`define OGD_NUM_OUT 12
`define OGD_NUM_LOOP 4
`define OGD_DIV_W 8
`define OGD_F_DIS 0
`define OGD_F_IDLE_HI 1
`define OGD_F_SYNC 2
`define OGD_F_LOL_DIS 3
`define OGD_F_SINGLE 4
`define OGD_F_INV_T 5
`define OGD_F_INV_C 6
`define OGD_F_W 7
`define OGD_G_REF_KEEP 0
`define OGD_G_3WIRE 1
`define OGD_G_W 2
`define OGD_OUT_RST 7'h04
`define OGD_GLB_RST 2'h0
`define OGD_PIN_RST 4'h6
`define OGD_OTP_PASSES 2
`define OGD_CLK_NS 20
`define OGD_LOAD_NS 1000
`define OGD_LOAD_CYC ((`OGD_LOAD_NS + `OGD_CLK_NS - 1) / `OGD_CLK_NS)
`endif

// ===== pkg/ogd_pkg.sv
// types for output gating and divider sync
package ogd_pkg;
   typedef enum logic [1:0] {OGD_LOAD, OGD_RUN} ogd_otp_st_t;
endpackage

// ===== verilog/ogd_cfg_store.sv
// nonvolatile configuration store with power-up load
`timescale 1ns/1ns
`include "ogd_consts.svh"
module ogd_cfg_store
   import ogd_pkg::*;
#(
   parameter int CFG_W = 86,
   parameter logic [CFG_W-1:0] DEFAULT_IMG = '0,
   parameter int LOAD_CYC = `OGD_LOAD_CYC
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_reload,
   input wire logic i_prog_stb,
   input wire logic [CFG_W-1:0] i_prog_img,
   output logic [CFG_W-1:0] o_cfg,
   output logic o_load_done,
   output logic o_loaded,
   output logic [1:0] o_passes,
   output logic o_prog_refused
);
   localparam int LC_W = $clog2(LOAD_CYC + 1);
   typedef struct packed {
      logic [1:0][CFG_W-1:0] img;
      logic [1:0] passes;
      ogd_otp_st_t st;
      logic [LC_W-1:0] cnt;
      logic [CFG_W-1:0] cfg;
      logic done;
      logic loaded;
      logic refused;
   } ogd_store_t;
   ogd_store_t s_q, s_d;

   always_comb begin
      s_d = s_q;
      s_d.done = 1'b0;
      s_d.refused = 1'b0;
      if (i_reload) begin
         s_d.st = OGD_LOAD;
         s_d.cnt = '0;
         s_d.loaded = 1'b0;
      end else begin
         case (s_q.st)
            OGD_LOAD: begin
               if (s_q.cnt == LC_W'(LOAD_CYC - 1)) begin
                  s_d.st = OGD_RUN;
                  s_d.done = 1'b1;
                  s_d.loaded = 1'b1;
                  // each load takes the newest programmed image, or the default if none is programmed
                  if (s_q.passes == 2'h0) s_d.cfg = DEFAULT_IMG;
                  else s_d.cfg = s_q.img[s_q.passes == 2'h2];
               end else begin
                  s_d.cnt = s_q.cnt + 1'b1;
               end
            end
            OGD_RUN: begin
               s_d.st = OGD_RUN;
            end
            default: begin
               s_d.st = OGD_LOAD;
            end
         endcase
      end
      if (i_prog_stb) begin
         if (s_q.st == OGD_RUN && s_q.passes < 2'(`OGD_OTP_PASSES)) begin
            s_d.img[s_q.passes[0]] = i_prog_img;
            s_d.passes = s_q.passes + 2'h1;
         end else begin
            s_d.refused = 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) s_q <= '{img: '0, passes: 2'h0, st: OGD_LOAD, cnt: '0,
                               cfg: '0, done: 1'b0, loaded: 1'b0, refused: 1'b0};
      else s_q <= s_d;
   end

   assign o_cfg = s_q.cfg;
   assign o_load_done = s_q.done;
   assign o_loaded = s_q.loaded;
   assign o_passes = s_q.passes;
   assign o_prog_refused = s_q.refused;

   sequence s_loading;
      !o_loaded [*8];
   endsequence
   property p_load_first;
      @(posedge i_clk) disable iff (!i_reset_n)
      $rose(i_reset_n) |-> s_loading;
   endproperty
   a_load_first: assert property (p_load_first) else $error("outputs live before load");
   property p_refuse;
      @(posedge i_clk) disable iff (!i_reset_n)
      (i_prog_stb && s_q.passes == 2'h2) |=> (o_prog_refused && o_passes == 2'h2);
   endproperty
   a_refuse: assert property (p_refuse) else $error("third pass accepted");
endmodule

// ===== verilog/ogd_out_drv.sv
// one clock output: divider, gating, idle level and polarity
`timescale 1ns/1ns
`include "ogd_consts.svh"
module ogd_out_drv
   import ogd_pkg::*;
#(
   parameter int DIV_W = `OGD_DIV_W
) (
   input wire logic i_clk,
   input wire logic i_reset_n,
   input wire logic i_div_rst,
   input wire logic [DIV_W-1:0] i_half,
   input wire logic i_en,
   input wire logic i_sync_en,
   input wire logic i_force_sync,
   input wire logic i_idle_hi,
   input wire logic i_single,
   input wire logic i_inv_t,
   input wire logic i_inv_c,
   output logic o_true,
   output logic o_comp,
   output logic o_active
);
   typedef struct packed {
      logic [DIV_W-1:0] cnt;
      logic ph;
      logic act;
      logic ot;
      logic oc;
   } ogd_drv_t;
   ogd_drv_t s_q, s_d;
   logic [DIV_W-1:0] last;
   logic wrap;
   logic edge_ok;

   always_comb begin
      s_d = s_q;
      last = (i_half == '0) ? '0 : i_half - 1'b1;
      wrap = (s_q.cnt >= last);
      // end of the low half closes a full period
      edge_ok = wrap && !s_q.ph;
      if (i_div_rst) begin
         s_d.cnt = '0;
         s_d.ph = 1'b1;
      end else if (wrap) begin
         s_d.cnt = '0;
         s_d.ph = !s_q.ph;
      end else begin
         s_d.cnt = s_q.cnt + 1'b1;
      end
      if (i_sync_en || i_force_sync) begin
         if (edge_ok || i_div_rst) s_d.act = i_en;
      end else begin
         s_d.act = i_en;
      end
      s_d.ot = s_d.act ? (s_d.ph ^ i_inv_t) : i_idle_hi;
      // single pin mode parks the complement to save power
      s_d.oc = (s_d.act && !i_single) ? (s_d.ph ^ i_inv_c) : i_idle_hi;
   end

   always_ff @(posedge i_clk) begin
      if (!i_reset_n) s_q <= '{cnt: '0, ph: 1'b1, act: 1'b0, ot: 1'b0, oc: 1'b0};
      else s_q <= s_d;
   end

   assign o_true = s_q.ot;
   assign o_comp = s_q.oc;
   assign o_active = s_q.act;

   property p_async_off;
      @(posedge i_clk) disable iff (!i_reset_n)
      (!i_sync_en && !i_force_sync && !i_en) |=> !o_active;
   endproperty
   a_async_off: assert property (p_async_off) else $error("late async disable");
   property p_sync_edge;
      @(posedge i_clk) disable iff (!i_reset_n)
      ((i_sync_en || i_force_sync) && !i_div_rst && !edge_ok) |=> $stable(o_active);
   endproperty
   a_sync_edge: assert property (p_sync_edge) else $error("mid-period switch");
   property p_idle;
      @(posedge i_clk) disable iff (!i_reset_n)
      !s_d.act |=> (o_true == $past(i_idle_hi));
   endproperty
   a_idle: assert property (p_idle) else $error("wrong idle level");
endmodule

// ===== bench/ogd_host_model.sv
// host side of the serial configuration port: data lines only
`timescale 1ns/1ns
module ogd_host_model (
   input wire logic i_clk,
   input wire logic i_rd_req,
   input wire logic i_data,
   input wire logic i_sdio,
   input wire logic i_sdio_oe_n,
   output logic o_spi_dout,
   output logic o_spi_dout_en,
   output logic o_sdi_pin,
   output logic o_sdio_pin
);
   logic tog_q = 1'b0;
   // a released line toggles so a stale level never passes for data
   always_ff @(posedge i_clk) begin
      tog_q <= ~tog_q;
   end
   assign o_spi_dout = i_data;
   assign o_spi_dout_en = i_rd_req;
   assign o_sdi_pin = i_data;
   // shared line: device wins while it drives, host releases while reading
   assign o_sdio_pin = !i_sdio_oe_n ? i_sdio : (i_rd_req ? tog_q : i_data);
endmodule

// ===== bench/output_gating_and_divider_sync_tb_top.sv
// self-checking bench for output gating and divider sync
`timescale 1ns/1ns
`include "ogd_consts.svh"
module output_gating_and_divider_sync_tb_top;
   import ogd_pkg::*;
   localparam int NO = 12;
   localparam int CW = NO*`OGD_F_W+`OGD_G_W;
   typedef struct {int sel; logic [CW-1:0] exp;} ogd_note_t;
   logic clk = 0, rst_n = 0, oe_pin = 0, pd_n = 1, i2c = 0, rbit = 0, sbit = 0;
   logic refl = 0, cfg_wr = 0, prog = 0, rd_req = 0, hdata = 0, ref_seen = 0;
   logic [3:0] loss_of_lock = '0;
   logic [23:0] loop_sel = '0;
   logic [95:0] half = '0;
   logic [CW-1:0] cfg_wd = '0, cfg_rd, wa, wb;
   logic [11:0] idl, dis, en_exp, en, ctrue, ccomp;
   logic [1:0] passes;
   logic refused, loaded, dout, dout_en, sdi, sdio_pin, spi_din, sdo, sdo_oe_n, sdio;
   logic sdio_oe_n, lowp, i2cm, drst;
   logic rst_pin = 1;
   logic [11:0] act;
   logic [3:0] fr;
   int fail_count = 0, compares = 0;
   ogd_note_t notes[$];
   event chk_ev;

   ogd_top #(.LOAD_CYC(8)) dut_u (
      .i_clk(clk), .i_reset_n(rst_n), .i_global_output_disable_pin(oe_pin),
      .i_power_down_pin_n(pd_n), .i_device_reset_pin_n(rst_pin), .i_i2c_sel_pin(i2c),
      .i_reset_bit(rbit), .i_div_sync_bit(sbit), .i_loss_of_lock(loss_of_lock),
      .i_reference_loss_alarm(refl), .i_out_loop_sel(loop_sel), .i_half(half),
      .i_cfg_wr(cfg_wr), .i_cfg_wdata(cfg_wd), .o_cfg_rdata(cfg_rd), .i_prog_stb(prog),
      .o_otp_passes(passes), .o_prog_refused(refused), .o_cfg_loaded(loaded),
      .i_spi_dout(dout), .i_spi_dout_en(dout_en), .i_sdi_pin(sdi), .i_sdio_pin(sdio_pin),
      .o_spi_din(spi_din), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_sdio(sdio),
      .o_sdio_oe_n(sdio_oe_n), .o_i2c_mode(i2cm), .o_clock_out_true(ctrue),
      .o_clock_out_comp(ccomp), .o_out_active(act), .o_out_enable(en), .o_loop_freerun(fr),
      .o_low_power(lowp), .o_div_rst(drst)
   );

   ogd_host_model host_u (
      .i_clk(clk), .i_rd_req(rd_req), .i_data(hdata), .i_sdio(sdio),
      .i_sdio_oe_n(sdio_oe_n), .o_spi_dout(dout), .o_spi_dout_en(dout_en),
      .o_sdi_pin(sdi), .o_sdio_pin(sdio_pin)
   );

   initial begin
      forever #10 clk = ~clk;
   end

   // a refusal is a one-cycle pulse, so it is caught here
   always @(posedge clk) begin
      if (refused === 1'b1) ref_seen <= 1'b1;
   end

   function automatic logic [CW-1:0] obs(int s);
      case (s)
         0: obs = cfg_rd;
         1: obs = CW'(en);
         2: obs = CW'(ctrue);
         3: obs = CW'(passes);
         4: obs = CW'({sdo_oe_n, sdio_oe_n});
         5: obs = CW'(lowp);
         6: obs = CW'(ctrue ^ ccomp);
         7: obs = CW'(spi_din);
         9: obs = CW'(drst);
         10: obs = CW'(i2cm);
         11: obs = CW'(act);
         12: obs = CW'(fr);
         13: obs = CW'({sdo, sdio});
         default: obs = CW'(ref_seen);
      endcase
   endfunction

   function automatic logic [CW-1:0] mk(logic [11:0] d, logic [11:0] il, logic [11:0] sy,
         logic [11:0] ld, logic [1:0] g);
      logic [CW-1:0] w;
      w = '0;
      for (int i = 0; i < NO; i++) begin
         w[i*`OGD_F_W+`OGD_F_DIS] = d[i];
         w[i*`OGD_F_W+`OGD_F_IDLE_HI] = il[i];
         w[i*`OGD_F_W+`OGD_F_SYNC] = sy[i];
         w[i*`OGD_F_W+`OGD_F_LOL_DIS] = ld[i];
      end
      w[NO*`OGD_F_W +: `OGD_G_W] = g;
      return w;
   endfunction

   // monitor: oldest note first, compared against what the outputs show now
   initial begin
      ogd_note_t n;
      logic [CW-1:0] got;
      forever begin
         @(chk_ev);
         while (notes.size() > 0) begin
            n = notes.pop_front();
            got = obs(n.sel);
            compares++;
            if (got !== n.exp) begin
               $display("BAD t=%0t exp=%h got=%h", $time, n.exp, got);
               fail_count++;
            end
         end
      end
   end

   task automatic note(int s, logic [CW-1:0] e);
      notes.push_back('{s, e});
      -> chk_ev;
   endtask

   task automatic cyc(int n);
      repeat (n) @(negedge clk);
   endtask

   task automatic stop_test();
      $display("mismatches=%0d compares=%0d", fail_count, compares);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   task automatic wait_loaded();
      int k;
      k = 0;
      while (loaded !== 1'b1 && k < 500) begin
         cyc(1);
         k++;
      end
      if (k >= 500) begin
         fail_count++;
         stop_test();
      end
   endtask

   task automatic wr(logic [CW-1:0] w);
      cfg_wr = 1'b1;
      cfg_wd = w;
      cyc(1);
      cfg_wr = 1'b0;
      cyc(1);
   endtask

   task automatic prg();
      prog = 1'b1;
      cyc(1);
      prog = 1'b0;
      cyc(2);
   endtask

   initial begin
      void'($urandom(53));
      for (int i = 0; i < NO; i++) begin
         half[i*8 +: 8] = 8'($urandom_range(4, 1));
         loop_sel[i*2 +: 2] = 2'(i % 4);
      end
      idl = 12'($urandom());
      dis = 12'($urandom());
      cyc(3);
      rst_n = 1'b1;
      wait_loaded();
      // the top register takes the loaded image one cycle after loaded rises
      cyc(1);
      note(0, mk(12'h000, 12'h000, 12'hfff, 12'h000, 2'h0));
      cyc(6);
      note(1, 12'hfff);
      wa = mk(12'h000, idl, 12'h000, 12'h111, 2'h0);
      wr(wa);
      cyc(4);
      for (int k = 0; k < 6; k++) begin
         cyc(1);
         note(6, 12'h000);
      end
      oe_pin = 1'b1;
      cyc(5);
      note(1, 12'h000);
      note(2, idl);
      cyc(10);
      note(2, idl);
      oe_pin = 1'b0;
      loss_of_lock = 4'h3;
      cyc(6);
      en_exp = ~12'h111;
      note(1, en_exp);
      loss_of_lock = 4'h0;
      refl = 1'b1;
      cyc(4);
      note(1, 12'h000);
      wr(mk(12'h000, idl, 12'h000, 12'h000, 2'h1));
      cyc(3);
      note(1, 12'hfff);
      refl = 1'b0;
      wr(mk(dis, idl, 12'h000, 12'h000, 2'h2));
      cyc(3);
      en_exp = ~dis;
      note(1, en_exp);
      hdata = 1'b1;
      cyc(5);
      note(7, 1'b1);
      rd_req = 1'b1;
      cyc(3);
      note(4, 2'h2);
      note(13, 2'h3);
      i2c = 1'b1;
      cyc(6);
      note(4, 2'h3);
      note(10, 1'b1);
      i2c = 1'b0;
      wr(wa);
      cyc(6);
      note(4, 2'h1);
      rd_req = 1'b0;
      prg();
      note(3, 2'h1);
      wb = mk(dis, 12'h000, 12'hfff, 12'h000, 2'h0);
      wr(wb);
      prg();
      note(3, 2'h2);
      prg();
      note(8, 1'b1);
      note(3, 2'h2);
      sbit = 1'b1;
      cyc(1);
      note(9, 1'b1);
      sbit = 1'b0;
      cyc(4);
      note(0, wb);
      pd_n = 1'b0;
      cyc(20);
      note(5, 1'b1);
      note(1, 12'h000);
      note(0, wb);
      note(12, 4'hf);
      note(11, 12'h000);
      pd_n = 1'b1;
      cyc(6);
      note(5, 1'b0);
      note(12, 4'h0);
      wr(wa);
      rbit = 1'b1;
      cyc(1);
      rbit = 1'b0;
      cyc(2);
      wait_loaded();
      cyc(1);
      note(0, wb);
      rst_pin = 1'b0;
      cyc(4);
      note(9, 1'b1);
      rst_pin = 1'b1;
      wait_loaded();
      cyc(1);
      note(0, wb);
      cyc(2);
      stop_test();
   end
endmodule
